// >>> mfp_far_end.sv
module mfp_far_end (
  input wire logic [1:0] mode,
  input wire logic       hdlc_clk,
  output logic     [7:0] data,
  output logic           lclk
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;

  // byte pattern; the count restarts whenever the far end goes idle
  assign data = 8'(cnt * 29 + 90);

  // 400 ns link clock, only within a frame; it always parks low
  initial lclk = 1'b0;
  always begin
    if (mode == 2'd1 || mode == 2'd2 || lclk) begin
      #200 lclk = ~lclk;
    end else begin
      @(mode);
      #17;
    end
  end

  // link-clock data moves on the edge opposite to the sampling one, so it stands still around it; hdlc data moves on the sampling rise
  always @(posedge lclk) if (mode == 2'd1) cnt <= cnt + 1;
  always @(negedge lclk) if (mode == 2'd2) cnt <= cnt + 1;
  always @(posedge hdlc_clk) if (mode == 2'd3) cnt <= cnt + 1;
  always @(mode) if (mode == 2'd0) cnt <= 0;
endmodule

// >>> mfp_fifo.sv
module mfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        pop;

  // honest flags straight from the occupancy count
  assign in_ready  = (s.count != CW'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rptr];

  // pointer and occupancy update
  always_comb begin
    next_s = s;
    push   = in_valid & in_ready;
    pop    = out_valid & out_ready;
    if (push) begin
      next_s.mem[s.wptr] = in_data;
      next_s.wptr = (s.wptr == PW'(DEPTH - 1)) ? '0 : s.wptr + PW'(1);
    end
    if (pop) begin
      next_s.rptr = (s.rptr == PW'(DEPTH - 1)) ? '0 : s.rptr + PW'(1);
    end
    if (push && !pop) begin
      next_s.count = s.count + CW'(1);
    end else if (pop && !push) begin
      next_s.count = s.count - CW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// >>> mfp_pin.sv
// offsets, field positions and reset values
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`include "mfp_regs.svh"

module mfp_pin #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        shared_bit3_in,
  output logic             shared_bit3_out,
  output logic             shared_bit3_oe_b,
  input  wire logic [6:0]  other_bits_in,
  input  wire logic        add_bus_ch1_clock,
  input  wire logic        slow_port_negative_data_in,
  output logic             slow_port_negative_data_out,
  output logic             slow_port_negative_data_oe_b,
  input  wire logic        slow_port_clock_in,
  output logic             slow_port_clock_out,
  output logic             slow_port_clock_oe_b,
  output logic             hdlc_tx_ch1_clock_out,
  input  wire logic        drop_valid,
  output logic             drop_ready,
  input  wire logic        drop_pos,
  input  wire logic        drop_neg,
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic [7:0]       word_data
);

  mfp_pkg::mfp_state_t s;
  mfp_pkg::mfp_state_t next_s;
  mfp_pkg::mfp_role_t  role;

  logic                       rst_meta_b;
  logic                       rst_sync_b;
  logic [`MFP_SYNC_WIDTH-1:0] raw_in;
  logic                       busclk_fall;
  logic                       spclk_rise;
  logic [7:0]                 samp_byte;
  logic [7:0]                 eff_div;
  logic                       tick;
  logic                       fifo_in_valid;
  logic                       fifo_in_ready;
  logic [7:0]                 fifo_in_data;
  logic                       fifo_empty;
  logic [31:0]                ctrl_word;
  logic [31:0]                stat_word;
  logic [31:0]                merged;

  // reset is applied asynchronously but is released only after two edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // every pin that crosses into this clock, one lane each
  assign raw_in = {other_bits_in,
                   slow_port_negative_data_in,
                   slow_port_clock_in,
                   add_bus_ch1_clock,
                   shared_bit3_in};

  // handshake outputs stay combinational for zero-wait acceptance
  assign s_axi_awready = ~s.aw_held & ~s.bvalid;
  assign s_axi_wready  = ~s.w_held & ~s.bvalid;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // pin-facing outputs all come from the state register
  assign shared_bit3_out              = s.pos_out;
  assign shared_bit3_oe_b             = s.data_oe_b;
  assign slow_port_negative_data_out  = s.neg_out;
  assign slow_port_negative_data_oe_b = s.data_oe_b;
  assign slow_port_clock_out          = s.sp_clk;
  assign slow_port_clock_oe_b         = s.sp_clk_oe_b;
  assign hdlc_tx_ch1_clock_out        = s.hdlc_clk;

  // add bus wins over the device mode; an unused mode code idles the pin
  // the reserved mode code behaves like no mode at all, so a bad write drives nothing
  always_comb begin
    if (s.bus_en) begin
      role = mfp_pkg::MFP_ROLE_ADD_BUS;
    end else begin
      case (s.mode)
        mfp_pkg::MFP_MODE_HDLC: begin
          role = mfp_pkg::MFP_ROLE_HDLC;
        end
        mfp_pkg::MFP_MODE_MAPPER: begin
          role = s.drop ? mfp_pkg::MFP_ROLE_SLOW_DROP : mfp_pkg::MFP_ROLE_SLOW_ADD;
        end
        default: begin
          role = mfp_pkg::MFP_ROLE_IDLE;
        end
      endcase
    end
  end

  // register views for the bus
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`MFP_CTRL_BUS_EN_BIT] = s.bus_en;
    ctrl_word[`MFP_CTRL_MODE_LSB +: 2] = s.mode;
    ctrl_word[`MFP_CTRL_DROP_BIT] = s.drop;
    ctrl_word[`MFP_CTRL_DIV_LSB +: 8] = s.div;
    stat_word = 32'h0000_0000;
    stat_word[`MFP_STAT_OVF_BIT] = s.ovf;
    stat_word[`MFP_STAT_EMPTY_BIT] = fifo_empty;
    stat_word[`MFP_STAT_ROLE_LSB +: 3] = role;
    stat_word[`MFP_STAT_LAST_LSB +: 8] = s.last;
  end

  // all next-state logic of the block
  always_comb begin
    next_s        = s;
    fifo_in_valid = 1'b0;
    fifo_in_data  = 8'h00;
    drop_ready    = 1'b0;
    merged        = ctrl_word;
    tick          = 1'b0;

    // three-stage synchronisers; a level counts once stages two and three agree
    // the agree test costs a cycle of latency but rejects a one-cycle glitch on a pin
    next_s.sync[0] = raw_in;
    next_s.sync[1] = s.sync[0];
    next_s.sync[2] = s.sync[1];
    for (int i = 0; i < `MFP_SYNC_WIDTH; i++) begin
      if (s.sync[1][i] == s.sync[2][i]) begin
        next_s.filt[i] = s.sync[2][i];
      end
    end
    busclk_fall = s.filt[`MFP_IN_BUSCLK] & ~next_s.filt[`MFP_IN_BUSCLK];
    spclk_rise  = ~s.filt[`MFP_IN_SPCLK] & next_s.filt[`MFP_IN_SPCLK];

    // data lanes travel the same depth as the clock lanes, so they line up
    samp_byte = {next_s.filt[`MFP_IN_REST_LSB + 6],
                 next_s.filt[`MFP_IN_REST_LSB + 5],
                 next_s.filt[`MFP_IN_REST_LSB + 4],
                 next_s.filt[`MFP_IN_REST_LSB + 3],
                 next_s.filt[`MFP_IN_POS],
                 next_s.filt[`MFP_IN_REST_LSB + 2],
                 next_s.filt[`MFP_IN_REST_LSB + 1],
                 next_s.filt[`MFP_IN_REST_LSB]};

    // a zero divider would stop the clock, so it acts as one
    // limitation: the HDLC byte is read some three cycles after the source moves it,
    // so a divider below two can take a byte before it has settled
    eff_div = (s.div == 8'h00) ? 8'h01 : s.div;

    // write path: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = `MFP_RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        if (s.w_strb[b]) begin
          merged[8*b +: 8] = s.w_data[8*b +: 8];
        end
      end
      if ({s.aw_addr[7:2], 2'b00} == `MFP_CTRL_OFFSET) begin
        next_s.bus_en = merged[`MFP_CTRL_BUS_EN_BIT];
        next_s.mode   = mfp_pkg::mfp_mode_t'(merged[`MFP_CTRL_MODE_LSB +: 2]);
        next_s.drop   = merged[`MFP_CTRL_DROP_BIT];
        next_s.div    = merged[`MFP_CTRL_DIV_LSB +: 8];
      end else if ({s.aw_addr[7:2], 2'b00} == `MFP_STAT_OFFSET) begin
        if (s.w_strb[0] && s.w_data[`MFP_STAT_OVF_BIT]) begin
          next_s.ovf = 1'b0; // write one to clear
        end
      end else begin
        // unmapped words answer with an error and change nothing
        next_s.bresp = `MFP_RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // read path answers one cycle after the address is taken
    // reads have no side effects, so status may be polled as often as wanted
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `MFP_RESP_OKAY;
      if ({s_axi_araddr[7:2], 2'b00} == `MFP_CTRL_OFFSET) begin
        next_s.rdata = ctrl_word;
      end else if ({s_axi_araddr[7:2], 2'b00} == `MFP_STAT_OFFSET) begin
        next_s.rdata = stat_word;
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = `MFP_RESP_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // per-role data movement
    // roles that follow an outside clock park the divider, so a switch begins with a full low phase
    case (role)
      mfp_pkg::MFP_ROLE_ADD_BUS: begin
        next_s.gen_clk = 1'b0;
        next_s.div_cnt = 8'h00;
        if (busclk_fall) begin
          fifo_in_valid = 1'b1;
          fifo_in_data  = samp_byte;
        end
      end
      mfp_pkg::MFP_ROLE_SLOW_ADD: begin
        next_s.gen_clk = 1'b0;
        next_s.div_cnt = 8'h00;
        if (spclk_rise) begin
          fifo_in_valid = 1'b1;
          fifo_in_data  = {6'h00, next_s.filt[`MFP_IN_NEG], next_s.filt[`MFP_IN_POS]};
        end
      end
      mfp_pkg::MFP_ROLE_HDLC, mfp_pkg::MFP_ROLE_SLOW_DROP: begin
        tick = (s.div_cnt >= eff_div - 8'h01);
        if (!tick) begin
          next_s.div_cnt = s.div_cnt + 8'h01;
        end else if (!s.gen_clk) begin
          // a full buffer holds the HDLC clock low, stalling the source
          if (role == mfp_pkg::MFP_ROLE_SLOW_DROP || fifo_in_ready) begin
            next_s.gen_clk = 1'b1;
            next_s.div_cnt = 8'h00;
            if (role == mfp_pkg::MFP_ROLE_HDLC) begin
              fifo_in_valid = 1'b1;
              fifo_in_data  = samp_byte;
            end
          end
        end else begin
          next_s.gen_clk = 1'b0;
          next_s.div_cnt = 8'h00;
          if (role == mfp_pkg::MFP_ROLE_SLOW_DROP) begin
            // an empty channel sends zeros rather than holding stale data
            drop_ready     = 1'b1;
            next_s.pos_out = drop_valid & drop_pos;
            next_s.neg_out = drop_valid & drop_neg;
          end
        end
      end
      default: begin
        next_s.gen_clk = 1'b0;
        next_s.div_cnt = 8'h00;
      end
    endcase

    // clock and pin drivers follow the role
    next_s.hdlc_clk    = next_s.gen_clk & (role == mfp_pkg::MFP_ROLE_HDLC);
    next_s.sp_clk      = next_s.gen_clk & (role == mfp_pkg::MFP_ROLE_SLOW_DROP);
    next_s.sp_clk_oe_b = (role != mfp_pkg::MFP_ROLE_SLOW_DROP);
    next_s.data_oe_b   = (role != mfp_pkg::MFP_ROLE_SLOW_DROP);
    if (role != mfp_pkg::MFP_ROLE_SLOW_DROP) begin
      next_s.pos_out = 1'b0;
      next_s.neg_out = 1'b0;
    end

    // pin sources cannot be paused, so a lost sample is flagged; set beats clear
    if (fifo_in_valid) begin
      if (fifo_in_ready) begin
        next_s.last = fifo_in_data;
      end else begin
        next_s.ovf = 1'b1;
      end
    end
  end

  // single state register
  // enables leave reset high, so no shared pin is driven before software picks a role
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s             <= '0;
      s.div         <= `MFP_DIV_RESET;
      s.sp_clk_oe_b <= 1'b1;
      s.data_oe_b   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // sampled words wait here for the ingress side
  // depth sets how long the ingress side may stall before pin samples are lost or the HDLC clock is held low
  mfp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_b     (rst_sync_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  assign fifo_empty = ~word_valid;

endmodule

// >>> mfp_pin_bench.sv
module mfp_pin_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rst_b = 1'b0, word_ready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, word_data, fe_data, p;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        drop_valid = 1'b0, drop_pos = 1'b0, drop_neg = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, word_valid, drop_ready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fe_mode = 2'd0;
  logic [6:0]  other_bits_in;
  logic        shared_bit3_in, shared_bit3_out, shared_bit3_oe_b, add_bus_ch1_clock, fe_clk;
  logic        slow_port_negative_data_in, slow_port_negative_data_out, slow_port_negative_data_oe_b;
  logic        slow_port_clock_in, slow_port_clock_out, slow_port_clock_oe_b, hdlc_tx_ch1_clock_out;
  int          failures = 0, checks_done = 0, t;

  always #25 clock = ~clock;

  // shared wires show the device while it drives them, else the far end
  assign shared_bit3_in = shared_bit3_oe_b ? fe_data[3] : shared_bit3_out;
  assign slow_port_negative_data_in = slow_port_negative_data_oe_b ? fe_data[1] : slow_port_negative_data_out;
  assign slow_port_clock_in = slow_port_clock_oe_b ? fe_clk : slow_port_clock_out;
  assign add_bus_ch1_clock = fe_clk;
  assign other_bits_in = {fe_data[7:4], fe_data[2:0]};

  mfp_pin dut (.*);
  mfp_far_end far (.mode(fe_mode), .hdlc_clk(hdlc_tx_ch1_clock_out), .data(fe_data), .lclk(fe_clk));

  // kind 0 hdlc, 1 add bus (first byte sampled after one count), 2 slow add rails
  function automatic logic [7:0] expw(int kind, int i);
    logic [7:0] b;
    b = 8'((i + (kind == 1)) * 29 + 90);
    return (kind == 2) ? {6'h00, b[1], b[3]} : b;
  endfunction

  task automatic check(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (!s_axi_bvalid && t < 50);
    s_axi_bready <= 1'b0;
    check({s_axi_bvalid, s_axi_bresp}, {1'b1, resp});
  endtask

  task automatic rd(logic [7:0] a, logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (!s_axi_rvalid && t < 50);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    check({s_axi_rvalid, s_axi_rresp}, {1'b1, resp});
  endtask

  // takes n words with the stream open and compares each against the pattern
  task automatic get_words(int n, int first, int kind);
    @(posedge clock);
    word_ready <= 1'b1;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(posedge clock);
        t++;
      end while (!word_valid && t < 400);
      check({word_valid, word_data}, {1'b1, expw(kind, first + k)});
    end
    word_ready <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // cut a hang short
  initial begin
    #500000;
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h00, 2'b00);
    check(rv, 32'h0000_0400);
    rd(8'h04, 2'b00);
    check(rv, 32'h0000_0002);
    wr(8'h08, 32'h0000_0003, 2'b10);
    rd(8'h08, 2'b10);
    check(rv, 32'h0000_0000);
    wr(8'h00, 32'h0000_0406, 2'b00);
    rd(8'h04, 2'b00);
    check(rv, 32'h0000_0002);
    // hdlc: stall on a full buffer, then drain with nothing lost
    fe_mode <= 2'd3;
    wr(8'h00, 32'h0000_0402, 2'b00);
    repeat (80) @(posedge clock);
    check(hdlc_tx_ch1_clock_out, 1'b0);
    rd(8'h04, 2'b00);
    check(rv[15:0], {expw(0, 3), 8'h20});
    get_words(8, 0, 0);
    repeat (60) @(posedge clock);
    wr(8'h00, 32'h0000_0400, 2'b00);
    get_words(4, 8, 0);
    fe_mode <= 2'd0;
    // add bus outranks hdlc mode; a full buffer loses samples and flags it
    wr(8'h00, 32'h0000_0403, 2'b00);
    fe_mode <= 2'd1;
    repeat (64) @(posedge clock);
    fe_mode <= 2'd0;
    repeat (20) @(posedge clock);
    check(hdlc_tx_ch1_clock_out, 1'b0);
    rd(8'h04, 2'b00);
    check(rv[15:0], {expw(1, 3), 8'h11});
    wr(8'h04, 32'h0000_0001, 2'b00);
    rd(8'h04, 2'b00);
    check(rv[15:0], {expw(1, 3), 8'h10});
    get_words(4, 0, 1);
    rd(8'h04, 2'b00);
    check(rv[1], 1'b1);
    // slow port add
    wr(8'h00, 32'h0000_0404, 2'b00);
    rd(8'h04, 2'b00);
    check(rv[6:4], 3'h3);
    fe_mode <= 2'd2;
    get_words(6, 0, 2);
    wr(8'h00, 32'h0000_0400, 2'b00);
    fe_mode <= 2'd0;
    word_ready <= 1'b1;
    repeat (20) @(posedge clock);
    word_ready <= 1'b0;
    // slow port drop: rails follow the taken bits, device drives the clock
    wr(8'h00, 32'h0000_040c, 2'b00);
    rd(8'h04, 2'b00);
    check(rv[6:4], 3'h4);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      p = expw(0, i);
      drop_valid <= (i < 5);
      drop_pos <= p[0];
      drop_neg <= p[2];
      t = 0;
      do begin
        @(posedge clock);
        t++;
      end while (!drop_ready && t < 40);
      @(negedge clock);
      check({t < 40, shared_bit3_oe_b, slow_port_negative_data_oe_b, slow_port_clock_oe_b, shared_bit3_out,
             slow_port_negative_data_out}, {4'b1000, p[0] & (i < 5), p[2] & (i < 5)});
    end
    check(word_valid, 1'b0);
    tally_and_finish();
  end
endmodule

// >>> mfp_pin_monitor.sv
module mfp_pin_monitor (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       hdlc_tx_ch1_clock_out,
  input wire logic       shared_bit3_out,
  input wire logic       shared_bit3_oe_b,
  input wire logic       slow_port_negative_data_out,
  input wire logic       slow_port_clock_out,
  input wire logic       slow_port_clock_oe_b,
  input wire logic       drop_valid,
  input wire logic       drop_ready,
  input wire logic       drop_pos,
  input wire logic       drop_neg,
  input wire logic       word_valid,
  input wire logic       word_ready,
  input wire logic [7:0] word_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain; the bench keeps the divider at its reset value of 4
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  hdlc_high_a: assert property (
    $rose(hdlc_tx_ch1_clock_out) |-> hdlc_tx_ch1_clock_out[*4] ##1 !hdlc_tx_ch1_clock_out)
    else $error("hdlc clock high phase wrong");
  hdlc_low_a: assert property (
    $fell(hdlc_tx_ch1_clock_out) |-> !hdlc_tx_ch1_clock_out[*4])
    else $error("hdlc clock low phase too short");
  hdlc_push_a: assert property (
    $rose(hdlc_tx_ch1_clock_out) |-> word_valid)
    else $error("no byte taken at hdlc clock rise");
  drop_data_a: assert property (
    drop_ready && drop_valid |=> shared_bit3_out == $past(drop_pos)
      && slow_port_negative_data_out == $past(drop_neg))
    else $error("dropped rails not driven");
  drop_edge_a: assert property (
    !shared_bit3_oe_b && !$past(shared_bit3_oe_b) && $changed(shared_bit3_out) |-> $fell(slow_port_clock_out))
    else $error("pin moved off the slow clock fall");
  drop_clock_a: assert property (
    drop_ready |=> $fell(slow_port_clock_out) ##1 !slow_port_clock_out[*3])
    else $error("slow clock did not fall after take");
  pin_drive_a: assert property (
    !shared_bit3_oe_b |-> !slow_port_clock_oe_b && !hdlc_tx_ch1_clock_out)
    else $error("pin driven outside drop role");
  word_hold_a: assert property (
    word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("word dropped while stalled");
endmodule

bind mfp_pin mfp_pin_monitor u_mon (
  .clock, .rst_b, .hdlc_tx_ch1_clock_out, .shared_bit3_out, .shared_bit3_oe_b,
  .slow_port_negative_data_out, .slow_port_clock_out, .slow_port_clock_oe_b,
  .drop_valid, .drop_ready, .drop_pos, .drop_neg, .word_valid, .word_ready, .word_data
);

// >>> mfp_pkg.sv
`include "mfp_regs.svh"

package mfp_pkg;

  typedef enum logic [1:0] {
    MFP_MODE_NONE   = 2'b00,
    MFP_MODE_HDLC   = 2'b01,
    MFP_MODE_MAPPER = 2'b10,
    MFP_MODE_SPARE  = 2'b11
  } mfp_mode_t;

  typedef enum logic [2:0] {
    MFP_ROLE_IDLE      = 3'b000,
    MFP_ROLE_ADD_BUS   = 3'b001,
    MFP_ROLE_HDLC      = 3'b010,
    MFP_ROLE_SLOW_ADD  = 3'b011,
    MFP_ROLE_SLOW_DROP = 3'b100
  } mfp_role_t;

  typedef struct packed {
    logic [2:0][`MFP_SYNC_WIDTH-1:0] sync;
    logic [`MFP_SYNC_WIDTH-1:0]      filt;
    logic                            bus_en;
    mfp_mode_t                       mode;
    logic                            drop;
    logic [7:0]                      div;
    logic                            ovf;
    logic [7:0]                      last;
    logic [7:0]                      div_cnt;
    logic                            gen_clk;
    logic                            hdlc_clk;
    logic                            sp_clk;
    logic                            sp_clk_oe_b;
    logic                            pos_out;
    logic                            neg_out;
    logic                            data_oe_b;
    logic                            aw_held;
    logic [7:0]                      aw_addr;
    logic                            w_held;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
  } mfp_state_t;

endpackage

// >>> mfp_regs.svh
`ifndef MFP_REGS_SVH
`define MFP_REGS_SVH

// register byte offsets
`define MFP_CTRL_OFFSET      8'h00
`define MFP_STAT_OFFSET      8'h04

// control register fields
`define MFP_CTRL_BUS_EN_BIT  0
`define MFP_CTRL_MODE_LSB    1
`define MFP_CTRL_DROP_BIT    3
`define MFP_CTRL_DIV_LSB     8
`define MFP_CTRL_RESET       32'h0000_0400
`define MFP_DIV_RESET        8'h04

// status register fields
`define MFP_STAT_OVF_BIT     0
`define MFP_STAT_EMPTY_BIT   1
`define MFP_STAT_ROLE_LSB    4
`define MFP_STAT_LAST_LSB    8

// bus responses
`define MFP_RESP_OKAY        2'b00
`define MFP_RESP_SLVERR      2'b10

// synchroniser lanes
`define MFP_SYNC_WIDTH       11
`define MFP_IN_POS           0
`define MFP_IN_BUSCLK        1
`define MFP_IN_SPCLK         2
`define MFP_IN_NEG           3
`define MFP_IN_REST_LSB      4

`endif
